// ### cbi_regs.svh
`ifndef CBI_REGS_SVH
`define CBI_REGS_SVH

// ==========================================================
// Fixed transaction attribute encodings
`define CBI_PROT_INSTR  3'h4
`define CBI_PROT_DATA   3'h0
`define CBI_CACHE_NONE  4'h0
`define CBI_CACHE_NCNB  4'h2
`define CBI_CACHE_NCB   4'h3
`define CBI_CACHE_WB    4'hf
`define CBI_QOS_NONE    4'h0
`define CBI_QOS_P7      4'h7
`define CBI_QOS_P8      4'h8
`define CBI_QOS_P12     4'hc
`define CBI_DOM_NONE    2'h0
`define CBI_DOM_INNER   2'h1

// ==========================================================
// Stream and buffer sizes
`define CBI_WORD_W      32
`define CBI_STRM_PORTS  16
`define CBI_FIFO_DEPTH  8

`endif

// ### cbi_pkg.sv
package cbi_pkg;
  // Stream read sequencer states, Gray coded along idle-wait-done
  typedef enum logic [1:0] {
    CBI_GET_IDLE = 2'h0,
    CBI_GET_WAIT = 2'h1,
    CBI_GET_DONE = 2'h3
  } cbi_get_state_t;
endpackage

// ### cbi_strm_if.sv
// ==========================================================
// Valid/ready word channel between the block's own modules
interface cbi_strm_if #(parameter int W = 33) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// ### cbi_fifo.sv
module cbi_fifo
  import cbi_pkg::*;
#(
  parameter int W     = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  cbi_strm_if.rx   wr,
  cbi_strm_if.tx   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // ==========================================================
  // Status, the extra pointer bit tells full from empty
  assign full     = (wptr_reg[AW] != rptr_reg[AW]) &&
                    (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty    = (wptr_reg == rptr_reg);
  assign push     = wr.valid && !full;
  assign pop      = rd.ready && !empty;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_reg[rptr_reg[AW-1:0]];

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  // Write pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
    end else if (push) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rptr_reg <= '0;
    end else if (pop) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule

// ### cbi_lmb.sv
module cbi_lmb
  import cbi_pkg::*;
#(
  parameter bit HAS_WR = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  output logic             busy,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             ce,
  output logic             ue,
  output logic [31:0]      bus_addr,
  output logic             bus_as,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic [3:0]       bus_be,
  output logic [31:0]      bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_ready,
  input  wire logic        bus_hold,
  input  wire logic        bus_ce,
  input  wire logic        bus_ue
);
  logic active_reg;
  logic wr_reg;
  logic issue;

  // ==========================================================
  // Issue when idle, or back to back in the completing cycle
  assign issue  = req && (!active_reg || bus_ready);
  assign busy   = req && !issue;
  assign bus_rd = active_reg && !wr_reg;
  assign bus_wr = active_reg && wr_reg;

  // Transfer in progress until ready is sampled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else if (issue) begin
      active_reg <= 1'b1;
    end else if (bus_ready) begin
      active_reg <= 1'b0;
    end
  end

  // Address strobe only in the first cycle of a transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_as <= 1'b0;
    end else begin
      bus_as <= issue;
    end
  end

  // Address, lanes and write data held from the issue edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_addr  <= '0;
      bus_be    <= '0;
      bus_wdata <= '0;
      wr_reg    <= 1'b0;
    end else if (issue) begin
      bus_addr  <= addr;
      bus_be    <= HAS_WR ? be : 4'h0;
      bus_wdata <= HAS_WR ? wdata : 32'h0;
      wr_reg    <= HAS_WR && wr;
    end
  end

  // Completion, read data and error flags of the finishing transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done  <= 1'b0;
      rdata <= '0;
      ce    <= 1'b0;
      ue    <= 1'b0;
    end else begin
      done <= active_reg && bus_ready;
      if (active_reg && bus_ready) begin
        rdata <= bus_rdata;
        ce    <= bus_ce;
        ue    <= bus_ue;
      end
    end
  end

  // ==========================================================
  // Checks
  as_one_cycle_a: assert property (
    @(posedge clk) disable iff (rst)
    bus_as && !bus_ready |=> !bus_as)
    else $error("address strobe held past first cycle");
  as_strobe_a: assert property (
    @(posedge clk) disable iff (rst)
    issue |=> bus_as && (bus_rd || bus_wr) && bus_addr == $past(addr))
    else $error("strobe or address missing at transfer start");
  hold_keeps_a: assert property (
    @(posedge clk) disable iff (rst)
    active_reg && bus_hold && !bus_ready |=> active_reg)
    else $error("transfer dropped while held");
  instr_no_wr_a: assert property (
    @(posedge clk) disable iff (rst)
    !HAS_WR |-> !bus_wr && bus_be == 4'h0)
    else $error("write activity on fetch side");
  single_cycle_a: assert property (
    @(posedge clk) disable iff (rst)
    bus_as && bus_ready |=> done)
    else $error("zero wait transfer not done next cycle");
endmodule

// ### cbi_top.sv
`include "cbi_regs.svh"
module cbi_top
  import cbi_pkg::*;
#(
  parameter bit DP_FULL = 1'b0,
  parameter bit IC_ACE  = 1'b0,
  parameter bit DC_ACE  = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  output logic [2:0]       IPERIPH_ARPROT,
  output logic [2:0]       DPERIPH_ARPROT,
  output logic [2:0]       DPERIPH_AWPROT,
  output logic [3:0]       DPERIPH_ARCACHE,
  output logic [3:0]       DPERIPH_AWCACHE,
  output logic [3:0]       DPERIPH_ARQOS,
  output logic [3:0]       DPERIPH_AWQOS,
  input  wire logic        ICACHE_DVM,
  output logic [3:0]       ICACHE_ARCACHE,
  output logic [2:0]       ICACHE_ARPROT,
  output logic [3:0]       ICACHE_ARQOS,
  output logic [1:0]       ICACHE_ARDOMAIN,
  input  wire logic        DCACHE_AR_EXCL,
  input  wire logic        DCACHE_AR_DVM,
  input  wire logic        DCACHE_AW_EXCL,
  output logic [3:0]       DCACHE_ARCACHE,
  output logic [3:0]       DCACHE_AWCACHE,
  output logic [2:0]       DCACHE_ARPROT,
  output logic [2:0]       DCACHE_AWPROT,
  output logic [3:0]       DCACHE_ARQOS,
  output logic [3:0]       DCACHE_AWQOS,
  output logic [1:0]       DCACHE_ARDOMAIN,
  output logic [1:0]       DCACHE_AWDOMAIN,
  output logic [15:0][31:0] SOUT_TDATA,
  output logic [15:0]      SOUT_TLAST,
  output logic [15:0]      SOUT_TVALID,
  input  wire logic [15:0] SOUT_TREADY,
  input  wire logic [15:0][31:0] SIN_TDATA,
  input  wire logic [15:0] SIN_TLAST,
  input  wire logic [15:0] SIN_TVALID,
  output logic [15:0]      SIN_TREADY,
  input  wire logic        PUT_REQ,
  input  wire logic        PUT_NONBLOCK,
  input  wire logic [3:0]  PUT_PORT,
  input  wire logic [31:0] PUT_DATA,
  input  wire logic        PUT_CTRL,
  output logic             PUT_STALL,
  output logic             PUT_CARRY,
  input  wire logic        GET_REQ,
  input  wire logic        GET_NONBLOCK,
  input  wire logic [3:0]  GET_PORT,
  output logic             GET_STALL,
  output logic             GET_DONE,
  output logic             GET_WRITE,
  output logic [31:0]      GET_DATA,
  output logic             GET_CTRL,
  output logic             GET_CARRY,
  input  wire logic        DLMB_REQ,
  input  wire logic        DLMB_WR,
  input  wire logic [31:0] DLMB_ADDR,
  input  wire logic [3:0]  DLMB_BE,
  input  wire logic [31:0] DLMB_WDATA,
  output logic             DLMB_STALL,
  output logic             DLMB_DONE,
  output logic [31:0]      DLMB_RDATA,
  output logic             DLMB_CE,
  output logic             DLMB_UE,
  output logic [31:0]      DATA_ADDR,
  output logic             DATA_ADDR_STROBE,
  output logic             DATA_RD_STROBE,
  output logic             DATA_WR_STROBE,
  output logic [3:0]       DATA_BE,
  output logic [31:0]      DATA_WDATA,
  input  wire logic [31:0] DATA_RDATA,
  input  wire logic        DATA_DONE,
  input  wire logic        DATA_HOLD,
  input  wire logic        DATA_CORRECTED_ERR,
  input  wire logic        DATA_UNCORRECTED_ERR,
  input  wire logic        ILMB_REQ,
  input  wire logic [31:0] ILMB_ADDR,
  output logic             ILMB_STALL,
  output logic             ILMB_DONE,
  output logic [31:0]      ILMB_RDATA,
  output logic             ILMB_CE,
  output logic             ILMB_UE,
  output logic [31:0]      INSTR_ADDR,
  output logic             INSTR_ADDR_STROBE,
  output logic             INSTR_FETCH_STROBE,
  input  wire logic [31:0] INSTR_RDATA,
  input  wire logic        INSTR_DONE,
  input  wire logic        INSTR_HOLD,
  input  wire logic        INSTR_CORRECTED_ERR,
  input  wire logic        INSTR_UNCORRECTED_ERR
);
  localparam int NP = `CBI_STRM_PORTS;
  localparam int WW = `CBI_WORD_W;

  cbi_get_state_t state_reg;
  logic [3:0]     gport_reg;
  logic [3:0]     sel_port;
  logic           sel_valid;
  logic           sel_last;
  logic           gactive;
  logic           take_now;
  logic [15:0]    put_sel;
  logic [15:0]    put_rdy;
  logic           port_rdy;

  // One-hot decode of a stream port number
  function automatic logic [15:0] port_dec(input logic [3:0] p);
    port_dec = 16'h0001 << p;
  endfunction

  // Data cache memory type from access kind
  function automatic logic [3:0] dc_cache(input logic excl,
                                          input logic dvm);
    if (DC_ACE && dvm) begin
      dc_cache = `CBI_CACHE_NCNB;
    end else if (!DC_ACE && excl) begin
      dc_cache = `CBI_CACHE_NCNB;
    end else begin
      dc_cache = `CBI_CACHE_WB;
    end
  endfunction

  // ==========================================================
  // Master port attributes, constants per port and kind
  assign IPERIPH_ARPROT  = `CBI_PROT_INSTR;
  assign DPERIPH_ARPROT  = `CBI_PROT_DATA;
  assign DPERIPH_AWPROT  = `CBI_PROT_DATA;
  assign DPERIPH_ARCACHE = DP_FULL ? `CBI_CACHE_NCB : `CBI_CACHE_NONE;
  assign DPERIPH_AWCACHE = DP_FULL ? `CBI_CACHE_NCB : `CBI_CACHE_NONE;
  assign DPERIPH_ARQOS   = DP_FULL ? `CBI_QOS_P8 : `CBI_QOS_NONE;
  assign DPERIPH_AWQOS   = DP_FULL ? `CBI_QOS_P8 : `CBI_QOS_NONE;

  // Instruction cache port
  assign ICACHE_ARCACHE  = (IC_ACE && ICACHE_DVM) ? `CBI_CACHE_NCNB
                                                  : `CBI_CACHE_WB;
  assign ICACHE_ARPROT   = `CBI_PROT_INSTR;
  assign ICACHE_ARQOS    = `CBI_QOS_P7;
  assign ICACHE_ARDOMAIN = IC_ACE ? `CBI_DOM_INNER : `CBI_DOM_NONE;

  // Data cache port
  assign DCACHE_ARCACHE  = dc_cache(DCACHE_AR_EXCL, DCACHE_AR_DVM);
  assign DCACHE_AWCACHE  = dc_cache(DCACHE_AW_EXCL, 1'b0);
  assign DCACHE_ARPROT   = `CBI_PROT_DATA;
  assign DCACHE_AWPROT   = `CBI_PROT_DATA;
  assign DCACHE_ARQOS    = `CBI_QOS_P12;
  assign DCACHE_AWQOS    = `CBI_QOS_P8;
  assign DCACHE_ARDOMAIN = DC_ACE ? `CBI_DOM_INNER : `CBI_DOM_NONE;
  assign DCACHE_AWDOMAIN = DC_ACE ? `CBI_DOM_INNER : `CBI_DOM_NONE;

  // ==========================================================
  // Stream writes: a port is busy while its buffer is full
  assign port_rdy  = put_rdy[PUT_PORT];
  assign put_sel   = PUT_REQ ? port_dec(PUT_PORT) : 16'h0000;
  assign PUT_STALL = PUT_REQ && !PUT_NONBLOCK && !port_rdy;
  assign PUT_CARRY = PUT_REQ && PUT_NONBLOCK && !port_rdy;

  // Per-port output buffer, control bit travels as TLAST
  for (genvar i = 0; i < NP; i++) begin : g_out
    cbi_strm_if #(.W(WW + 1)) in_s ();
    cbi_strm_if #(.W(WW + 1)) out_s ();

    assign in_s.valid     = put_sel[i];
    assign in_s.data      = {PUT_CTRL, PUT_DATA};
    assign put_rdy[i]     = in_s.ready;
    assign SOUT_TVALID[i] = out_s.valid;
    assign SOUT_TDATA[i]  = out_s.data[WW-1:0];
    assign SOUT_TLAST[i]  = out_s.data[WW];
    assign out_s.ready    = SOUT_TREADY[i];

    cbi_fifo #(.W(WW + 1), .DEPTH(`CBI_FIFO_DEPTH)) u_fifo (
      .clk (CLK),
      .rst (RESET),
      .wr  (in_s),
      .rd  (out_s)
    );
  end

  // ==========================================================
  // Stream reads: take a word from the selected input port
  assign sel_port   = (state_reg == CBI_GET_WAIT) ? gport_reg : GET_PORT;
  assign sel_valid  = SIN_TVALID[sel_port];
  assign sel_last   = SIN_TLAST[sel_port];
  assign gactive    = (state_reg == CBI_GET_WAIT) ||
                      (state_reg == CBI_GET_IDLE && GET_REQ);
  assign take_now   = gactive && sel_valid;
  assign SIN_TREADY = take_now ? port_dec(sel_port) : 16'h0000;
  assign GET_STALL  = (state_reg == CBI_GET_WAIT);
  assign GET_DONE   = (state_reg == CBI_GET_DONE);

  // Read sequencer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= CBI_GET_IDLE;
    end else begin
      unique case (state_reg)
        CBI_GET_IDLE: begin
          if (GET_REQ && (sel_valid || GET_NONBLOCK)) begin
            state_reg <= CBI_GET_DONE;
          end else if (GET_REQ) begin
            state_reg <= CBI_GET_WAIT;
          end
        end
        CBI_GET_WAIT: begin
          if (sel_valid) begin
            state_reg <= CBI_GET_DONE;
          end
        end
        CBI_GET_DONE: begin
          state_reg <= CBI_GET_IDLE;
        end
        default: begin
          state_reg <= CBI_GET_IDLE;
        end
      endcase
    end
  end

  // Port held across a stall
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      gport_reg <= 4'h0;
    end else if (state_reg == CBI_GET_IDLE && GET_REQ) begin
      gport_reg <= GET_PORT;
    end
  end

  // Result word, control bit, write enable and carry
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      GET_DATA  <= 32'h0;
      GET_CTRL  <= 1'b0;
      GET_WRITE <= 1'b0;
      GET_CARRY <= 1'b0;
    end else if (take_now) begin
      GET_DATA  <= SIN_TDATA[sel_port];
      GET_CTRL  <= sel_last;
      GET_WRITE <= 1'b1;
      GET_CARRY <= 1'b0;
    end else if (state_reg == CBI_GET_IDLE && GET_REQ && GET_NONBLOCK) begin
      GET_WRITE <= 1'b0;
      GET_CARRY <= 1'b1;
    end else if (state_reg == CBI_GET_DONE) begin
      GET_WRITE <= 1'b0;
      GET_CARRY <= 1'b0;
    end
  end

  // ==========================================================
  // Local memory bus masters, data side and fetch side
  cbi_lmb #(.HAS_WR(1'b1)) u_dlmb (
    .clk       (CLK),
    .rst       (RESET),
    .req       (DLMB_REQ),
    .wr        (DLMB_WR),
    .addr      (DLMB_ADDR),
    .be        (DLMB_BE),
    .wdata     (DLMB_WDATA),
    .busy      (DLMB_STALL),
    .done      (DLMB_DONE),
    .rdata     (DLMB_RDATA),
    .ce        (DLMB_CE),
    .ue        (DLMB_UE),
    .bus_addr  (DATA_ADDR),
    .bus_as    (DATA_ADDR_STROBE),
    .bus_rd    (DATA_RD_STROBE),
    .bus_wr    (DATA_WR_STROBE),
    .bus_be    (DATA_BE),
    .bus_wdata (DATA_WDATA),
    .bus_rdata (DATA_RDATA),
    .bus_ready (DATA_DONE),
    .bus_hold  (DATA_HOLD),
    .bus_ce    (DATA_CORRECTED_ERR),
    .bus_ue    (DATA_UNCORRECTED_ERR)
  );

  // Fetch side: read strobe serves as the fetch indication
  cbi_lmb #(.HAS_WR(1'b0)) u_ilmb (
    .clk       (CLK),
    .rst       (RESET),
    .req       (ILMB_REQ),
    .wr        (1'b0),
    .addr      (ILMB_ADDR),
    .be        (4'h0),
    .wdata     (32'h0),
    .busy      (ILMB_STALL),
    .done      (ILMB_DONE),
    .rdata     (ILMB_RDATA),
    .ce        (ILMB_CE),
    .ue        (ILMB_UE),
    .bus_addr  (INSTR_ADDR),
    .bus_as    (INSTR_ADDR_STROBE),
    .bus_rd    (INSTR_FETCH_STROBE),
    .bus_wr    (),
    .bus_be    (),
    .bus_wdata (),
    .bus_rdata (INSTR_RDATA),
    .bus_ready (INSTR_DONE),
    .bus_hold  (INSTR_HOLD),
    .bus_ce    (INSTR_CORRECTED_ERR),
    .bus_ue    (INSTR_UNCORRECTED_ERR)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  dc_excl_a: assert property (
    !DC_ACE && DCACHE_AR_EXCL |-> DCACHE_ARCACHE == `CBI_CACHE_NCNB)
    else $error("exclusive read memory type wrong");
  dvm_type_a: assert property (
    IC_ACE && ICACHE_DVM |-> ICACHE_ARCACHE == `CBI_CACHE_NCNB)
    else $error("DVM memory type wrong");
  put_block_a: assert property (
    PUT_REQ && !PUT_NONBLOCK && port_rdy
    |-> !PUT_STALL ##1 SOUT_TVALID[$past(PUT_PORT)])
    else $error("blocking put stalled on free port");
  put_nb_a: assert property (
    PUT_REQ && PUT_NONBLOCK |-> !PUT_STALL && (PUT_CARRY == !port_rdy))
    else $error("non-blocking put carry or stall wrong");
  get_two_a: assert property (
    state_reg == CBI_GET_IDLE && GET_REQ && sel_valid
    |=> GET_DONE && GET_WRITE ##1 !GET_DONE)
    else $error("blocking get not done in two cycles");
  get_wait_a: assert property (
    GET_STALL && !sel_valid |=> GET_STALL && !GET_DONE)
    else $error("get left wait without data");
  get_nb_a: assert property (
    state_reg == CBI_GET_IDLE && GET_REQ && GET_NONBLOCK && !sel_valid
    |=> GET_DONE && !GET_WRITE && GET_CARRY)
    else $error("empty non-blocking get wrong");
  get_last_a: assert property (
    take_now |=> GET_CTRL == $past(sel_last))
    else $error("control bit not taken from TLAST");

  put_stall_c: cover property (PUT_STALL ##1 !PUT_STALL && PUT_REQ);
  get_wait_c: cover property (GET_STALL ##1 GET_DONE);
  get_carry_c: cover property (GET_DONE && GET_CARRY);
endmodule

// ### cbi_lmb_mem.sv
// ==========================================================
// Local memory partner: block RAM controller with wait states
module cbi_lmb_mem #(
  parameter logic [31:0] BASE = 32'h0
) (
  input  wire logic        clk,
  input  wire logic [31:0] addr,
  input  wire logic        as,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  waits,
  input  wire logic [1:0]  err,
  output logic [31:0]      rdata,
  output logic             done,
  output logic             hold,
  output logic             ce,
  output logic             ue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [3:0]  a_reg;
  logic [3:0]  cnt;
  logic        pend;
  wire  [3:0]  idx = as ? addr[5:2] : a_reg;
  // Preset contents and idle state
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = BASE + 32'(i);
    pend = 1'h0;
    last = 32'h0;
  end
  // Ready after the commanded wait states, none means same cycle
  assign done  = (as && waits == 4'h0) || (pend && cnt == waits);
  assign hold  = pend && !done;
  assign ce    = done && err[0];
  assign ue    = done && err[1];
  assign rdata = done ? mem[idx] : ~last;
  // Transfer tracking and write storage
  always @(posedge clk) begin
    if (as) a_reg <= addr[5:2];
    if (as && waits != 4'h0) begin
      pend <= 1'h1;
      cnt  <= 4'h1;
    end else if (pend && done) pend <= 1'h0;
    else if (pend) cnt <= cnt + 4'h1;
    if (done && wr) mem[idx] <= wdata;
    last <= rdata;
  end
endmodule

// ### cbi_top_tb_top.sv
module cbi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET, ICACHE_DVM, DCACHE_AR_EXCL, DCACHE_AR_DVM, DCACHE_AW_EXCL;
  logic [2:0] IPERIPH_ARPROT, DPERIPH_ARPROT, DPERIPH_AWPROT, ICACHE_ARPROT;
  logic [2:0] DCACHE_ARPROT, DCACHE_AWPROT;
  logic [3:0] DPERIPH_ARCACHE, DPERIPH_AWCACHE, DPERIPH_ARQOS, DPERIPH_AWQOS;
  logic [3:0] ICACHE_ARCACHE, ICACHE_ARQOS, DCACHE_ARCACHE, DCACHE_AWCACHE;
  logic [3:0] DCACHE_ARQOS, DCACHE_AWQOS, PUT_PORT, GET_PORT, DLMB_BE, DATA_BE;
  logic [1:0] ICACHE_ARDOMAIN, DCACHE_ARDOMAIN, DCACHE_AWDOMAIN;
  logic PUT_REQ, PUT_NONBLOCK, PUT_CTRL, PUT_STALL, PUT_CARRY, GET_REQ;
  logic GET_NONBLOCK, GET_STALL, GET_DONE, GET_WRITE, GET_CTRL, GET_CARRY;
  logic [15:0][31:0] SOUT_TDATA, SIN_TDATA;
  logic [15:0] SOUT_TLAST, SOUT_TVALID, SOUT_TREADY;
  logic [15:0] SIN_TLAST, SIN_TVALID, SIN_TREADY;
  logic [31:0] PUT_DATA, GET_DATA, DLMB_ADDR, DLMB_WDATA, DLMB_RDATA;
  logic [31:0] DATA_ADDR, DATA_WDATA, DATA_RDATA;
  logic [31:0] ILMB_ADDR, ILMB_RDATA, INSTR_ADDR, INSTR_RDATA;
  logic DLMB_REQ, DLMB_WR, DLMB_STALL, DLMB_DONE, DLMB_CE, DLMB_UE;
  logic DATA_ADDR_STROBE, DATA_RD_STROBE, DATA_WR_STROBE, DATA_DONE, DATA_HOLD;
  logic DATA_CORRECTED_ERR, DATA_UNCORRECTED_ERR, ILMB_REQ, ILMB_STALL;
  logic ILMB_DONE, ILMB_CE, ILMB_UE, INSTR_ADDR_STROBE, INSTR_FETCH_STROBE;
  logic INSTR_DONE, INSTR_HOLD, INSTR_CORRECTED_ERR, INSTR_UNCORRECTED_ERR;
  logic [3:0] data_hold, instr_hold;
  logic [1:0] derr, ierr;
  int         failures, comparisons;
  // ==========================================================
  // Design and local memory partners
  cbi_top #(.DP_FULL(1'h1), .IC_ACE(1'h1)) dut (.*);
  cbi_lmb_mem #(.BASE(32'h00d0_0000)) dmem (.clk(CLK), .addr(DATA_ADDR),
    .as(DATA_ADDR_STROBE), .wr(DATA_WR_STROBE), .wdata(DATA_WDATA),
    .waits(data_hold), .err(derr), .rdata(DATA_RDATA), .done(DATA_DONE),
    .hold(DATA_HOLD), .ce(DATA_CORRECTED_ERR), .ue(DATA_UNCORRECTED_ERR));
  cbi_lmb_mem #(.BASE(32'h00c0_0000)) imem (.clk(CLK), .addr(INSTR_ADDR),
    .as(INSTR_ADDR_STROBE), .wr(1'h0), .wdata(DATA_WDATA), .waits(instr_hold),
    .err(ierr), .rdata(INSTR_RDATA), .done(INSTR_DONE), .hold(INSTR_HOLD),
    .ce(INSTR_CORRECTED_ERR), .ue(INSTR_UNCORRECTED_ERR));
  // Clock
  always #10 CLK = ~CLK;
  // ==========================================================
  // Comparison and closing
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Attribute constants over every access kind
  task automatic t_attr;
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK) #1;
      {DCACHE_AR_EXCL, DCACHE_AR_DVM, DCACHE_AW_EXCL} = 3'(i);
      ICACHE_DVM = i[1];
      #1;
      chk({IPERIPH_ARPROT, ICACHE_ARPROT}, 6'h24);
      chk({DPERIPH_ARPROT, DPERIPH_AWPROT, DCACHE_ARPROT, DCACHE_AWPROT}, 0);
      chk({DPERIPH_ARCACHE, DPERIPH_AWCACHE}, 8'h33);
      chk({DPERIPH_ARQOS, DPERIPH_AWQOS}, 8'h88);
      chk(ICACHE_ARQOS, 4'h7);
      chk(ICACHE_ARCACHE, i[1] ? 4'h2 : 4'hf);
      chk(ICACHE_ARDOMAIN, 2'h1);
      chk({DCACHE_ARDOMAIN, DCACHE_AWDOMAIN}, 4'h0);
      chk(DCACHE_ARCACHE, i[2] ? 4'h2 : 4'hf);
      chk(DCACHE_AWCACHE, i[0] ? 4'h2 : 4'hf);
      chk({DCACHE_ARQOS, DCACHE_AWQOS}, 8'hc8);
    end
  endtask
  // Fill port 3 while stalled, refuse, then drain
  task automatic t_put;
    int   n;
    logic s;
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK) #1;
      {PUT_REQ, PUT_NONBLOCK, PUT_PORT} = {1'h1, i == 8, 4'h3};
      {PUT_DATA, PUT_CTRL} = {32'h5000_0000 + 32'(i), i == 0};
      if (i == 9) SOUT_TREADY = 16'h0008;
      #1;
      chk({PUT_STALL, PUT_CARRY}, i == 8 ? 2'h1 : {i == 9, 1'h0});
    end
    n = 0;
    for (int j = 0; j < 12; j++) begin
      if (SOUT_TVALID[3] === 1'h1) begin
        chk(SOUT_TDATA[3], 32'h5000_0000 + 32'(n == 8 ? 9 : n));
        chk(SOUT_TLAST[3], n == 0);
        n++;
      end
      s = PUT_STALL;
      @(posedge CLK) #1;
      if (s !== 1'h1) PUT_REQ = 1'h0;
      #1;
    end
    chk(n, 9);
  endtask
  // Blocking with data, non-blocking empty, blocking stall
  task automatic t_get;
    int k;
    @(posedge CLK) #1;
    {SIN_TVALID, SIN_TLAST, SIN_TDATA[5]} = {16'h0020, 16'h0020, 32'h6000_00a5};
    {GET_REQ, GET_NONBLOCK, GET_PORT} = {1'h1, 1'h0, 4'h5};
    #1;
    chk(SIN_TREADY, 16'h0020);
    @(posedge CLK) #1;
    {GET_REQ, SIN_TVALID, SIN_TDATA[5]} = {1'h0, 16'h0, 32'h9fff_ff5a};
    #1;
    chk({GET_DONE, GET_WRITE, GET_CTRL, GET_CARRY}, 4'he);
    chk(GET_DATA, 32'h6000_00a5);
    @(posedge CLK) #1;
    {GET_REQ, GET_NONBLOCK} = 2'h3;
    @(posedge CLK) #1;
    GET_REQ = 1'h0;
    #1;
    chk({GET_DONE, GET_WRITE, GET_CARRY}, 3'h5);
    @(posedge CLK) #1;
    {GET_REQ, GET_NONBLOCK, GET_PORT} = {1'h1, 1'h0, 4'hf};
    @(posedge CLK) #1;
    GET_REQ = 1'h0;
    #1;
    chk({GET_STALL, GET_DONE}, 2'h2);
    @(posedge CLK) #1;
    {SIN_TVALID, SIN_TLAST, SIN_TDATA[15]} = {16'h8000, 16'h0, 32'h6000_f00f};
    k = 0;
    do begin
      @(posedge CLK) #1;
      {SIN_TVALID, SIN_TDATA[15]} = {16'h0, 32'h9fff_0ff0};
      k++;
    end while (GET_DONE !== 1'h1 && k < 6);
    chk(GET_DATA, 32'h6000_f00f);
    chk({GET_WRITE, GET_CTRL}, 2'h2);
  endtask
  // Data side transfer with wait states and error flags
  task automatic lmb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] n, input logic [1:0] f);
    int k;
    @(posedge CLK) #1;
    {data_hold, derr, DLMB_REQ, DLMB_WR, DLMB_ADDR, DLMB_WDATA} = {n, f, 1'h1, w, a, d};
    #1;
    chk(DLMB_STALL, 0);
    @(posedge CLK) #1;
    DLMB_REQ = 1'h0;
    #1;
    chk({DATA_ADDR_STROBE, DATA_WR_STROBE, DATA_RD_STROBE}, {1'h1, w, !w});
    chk(DATA_ADDR, a);
    if (w) chk({DATA_WDATA[27:0], DATA_BE}, {d[27:0], 4'hf});
    k = 0;
    do begin
      @(posedge CLK) #1;
      k++;
      #1;
      chk(DATA_ADDR_STROBE, 0);
    end while (DLMB_DONE !== 1'h1 && k < 12);
    chk(k, n + 1);
    chk({DLMB_UE, DLMB_CE}, f);
    if (!w) chk(DLMB_RDATA, d);
  endtask
  // Instruction fetch with one wait state
  task automatic t_fetch;
    @(posedge CLK) #1;
    {ILMB_REQ, ILMB_ADDR, instr_hold, ierr} = {1'h1, 32'h8, 4'h1, 2'h2};
    @(posedge CLK) #1;
    ILMB_REQ = 1'h0;
    #1;
    chk({INSTR_ADDR_STROBE, INSTR_FETCH_STROBE}, 2'h3);
    chk(INSTR_ADDR, 32'h8);
    repeat (2) @(posedge CLK);
    #2;
    chk({ILMB_DONE, ILMB_UE, ILMB_CE}, 3'h6);
    chk(ILMB_RDATA, 32'h00c0_0002);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {CLK, RESET, failures, comparisons, SIN_TDATA, SOUT_TREADY} = {2'h1, 64'h0, 528'h0};
    {ICACHE_DVM, DCACHE_AR_EXCL, DCACHE_AR_DVM, DCACHE_AW_EXCL} = 4'h0;
    {PUT_REQ, PUT_NONBLOCK, PUT_PORT, PUT_DATA, PUT_CTRL} = 0;
    {GET_REQ, GET_NONBLOCK, GET_PORT, SIN_TLAST, SIN_TVALID} = 0;
    {DLMB_REQ, DLMB_WR, DLMB_ADDR, DLMB_BE, DLMB_WDATA} = {69'h0, 4'hf, 32'h0};
    {ILMB_REQ, ILMB_ADDR, data_hold, instr_hold, derr, ierr} = 0;
    repeat (5) @(posedge CLK);
    #1 RESET = 1'h0;
    t_attr();
    t_put();
    t_get();
    lmb(1'h1, 32'h10, 32'hcafe_0001, 4'h0, 2'h0);
    lmb(1'h0, 32'h10, 32'hcafe_0001, 4'h3, 2'h1);
    lmb(1'h0, 32'h14, 32'h00d0_0005, 4'h0, 2'h2);
    t_fetch();
    report_and_stop();
  end
  // Watchdog: all scenarios finish in well under 2000 cycles
  initial begin
    #40000;
    failures++;
    report_and_stop();
  end
endmodule
